// file: hdl/slc_defs.svh
// Register offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH
`define SLC_OFS_CTRL         4'h0
`define SLC_OFS_STANDBY_RUN  4'h4
`define SLC_OFS_CFG          4'h8
`define SLC_OFS_STATUS       4'hC
`define SLC_CTRL_RESET       8'h00
`define SLC_CTRL_ARM_BIT     0
`define SLC_CTRL_MODE_LSB    1
`define SLC_CTRL_MODE_MSB    2
`define SLC_MODE_IDLE        2'h0
`define SLC_MODE_STANDBY     2'h1
`define SLC_MODE_POWER_DOWN  2'h2
`define SLC_MODE_RESERVED    2'h3
`define SLC_STBY_RESET       8'h00
`define SLC_CFG_RESET        8'h00
`define SLC_WAKE_CLKS        4'h6
`define SLC_OSC_START_CLKS   8'h20
`define SLC_BOD_WAIT_CODE    2'h3
`define SLC_NUM_PERIPH       8
`define SLC_PERIPH_RTC       0
`define SLC_PERIPH_CCL       1
`define SLC_PERIPH_TCA       2
`define SLC_PERIPH_USART     3
`define SLC_PERIPH_MAIN_CLK  4
`endif

// file: hdl/slc_pkg.sv
// Types shared by the sleep controller modules
package slc_pkg;
   typedef enum logic [2:0] {
      SLC_ACTIVE  = 3'b000,
      SLC_SLEEP   = 3'b001,
      SLC_OSC     = 3'b010,
      SLC_WAKE    = 3'b011,
      SLC_BOD     = 3'b100,
      SLC_STUCK   = 3'b101
   } slc_state_e;
   typedef logic [7:0] slc_byte_t;
endpackage : slc_pkg

// file: hdl/slc_wake_if.sv
// Wake qualification signals between controller and wake filter
`timescale 1ns/1ns
interface slc_wake_if;
   logic [1:0] mode;
   logic [7:0] standby_run;
   logic       lut_async;
   logic       wake;
   logic       any_enabled;
   modport ctrl (output mode, output standby_run, output lut_async, input wake, input any_enabled);
   modport filt (input mode, input standby_run, input lut_async, output wake, output any_enabled);
endinterface : slc_wake_if

// file: hdl/slc_wake_filter.sv
// Wake source filtering per sleep mode
`timescale 1ns/1ns
`include "slc_defs.svh"
module slc_wake_filter (
   input  wire logic        clk,
   input  wire logic        ce,
   input  wire logic        rst,
   input  wire logic [10:0] irq_sync,
   input  wire logic [10:0] irq_en,
   slc_wake_if.filt         wk
);
   import slc_pkg::*;
   // Sources: 0 pin, 1 twi match, 2 vlm, 3 ccl, 4 rtc pit, 5 rtc other, 6 usart sof, 7 usart other,
   // 8 tca, 9 other, 10 spare other
   logic [10:0] pend;
   logic [10:0] allow;
   always_comb begin
      pend = irq_sync & irq_en;
      allow = 11'h7FF;
      if (wk.mode == `SLC_MODE_STANDBY) begin
         allow[3]  = wk.standby_run[`SLC_PERIPH_CCL] & wk.lut_async;
         allow[4]  = wk.standby_run[`SLC_PERIPH_RTC];
         allow[5]  = wk.standby_run[`SLC_PERIPH_RTC];
         allow[6]  = wk.standby_run[`SLC_PERIPH_USART];
         allow[7]  = 1'b0;
         allow[8]  = wk.standby_run[`SLC_PERIPH_TCA];
         allow[9]  = 1'b0;
         allow[10] = 1'b0;
      end else if (wk.mode == `SLC_MODE_POWER_DOWN) begin
         allow = 11'h017;
         allow[3] = wk.lut_async;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wk.wake <= 1'b0;
         wk.any_enabled <= 1'b0;
      end else if (ce) begin
         wk.wake <= |(pend & allow);
         wk.any_enabled <= |(irq_en & allow);
      end
   end
endmodule : slc_wake_filter

// file: hdl/slc_gates.sv
// Peripheral and clock gating per sleep mode
`timescale 1ns/1ns
`include "slc_defs.svh"
module slc_gates (
   input  wire logic       asleep,
   input  wire logic [1:0] mode,
   input  wire logic [7:0] standby_run,
   output logic      [7:0] periph_run,
   output logic            main_clk_run,
   output logic            ccl_clk_run,
   output logic            rtc_clk_run
);
   always_comb begin
      periph_run = 8'hFF;
      main_clk_run = 1'b1;
      ccl_clk_run = 1'b1;
      rtc_clk_run = 1'b1;
      if (asleep && mode == `SLC_MODE_STANDBY) begin
         periph_run = standby_run;
         main_clk_run = standby_run[`SLC_PERIPH_MAIN_CLK];
         ccl_clk_run = standby_run[`SLC_PERIPH_CCL];
         rtc_clk_run = standby_run[`SLC_PERIPH_RTC];
      end else if (asleep && mode == `SLC_MODE_POWER_DOWN) begin
         periph_run = 8'h01;
         main_clk_run = 1'b0;
         ccl_clk_run = 1'b0;
         rtc_clk_run = 1'b1;
      end
   end
endmodule : slc_gates

// file: hdl/slc_sleep_ctrl.sv
// Sleep controller top with Avalon-MM register slave
// Overview of operation
// - With no wake interrupt enabled, sleep lasts until reset or a debug break.
// - Only the sleep instruction enters sleep; register writes never halt the CPU.
// - Idle halts the CPU, keeps peripherals running, any interrupt wakes.
// - Standby runs only peripherals whose run-in-standby bit is set.
// - Power-down keeps only brownout, watchdog and periodic timer active.
// - Power-down wakes on pin, periodic timer, voltage monitor, TWO_WIRE_INTERFACE match, logic.
// - Standby keeps main and logic clocks only for run-in-standby users.
// - RTC needs run-in-standby in standby; only periodic timer in power-down.
// - Timer type A wakes from standby only with run-in-standby set.
// - Configurable logic wakes standby and power-down only if filter and edge fields are zero.
// - USART wakes standby only on start-of-frame, never power-down.
// - Wake takes six clocks plus oscillator start when it was stopped.
// - Idle keeps the main clock source running.
// - Power-down stops all clocks except ultra-low-power and RTC clocks.
// - Brownout mode 3 delays execution until the detector is ready.
// - A debug break wakes the device to active mode.
// - Control register resets to zero; bits 7 to 3 read zero.
// - Mode codes: idle 0, standby 1, power-down 2, 3 reserved.
// - Sleep instruction sleeps only if arm bit was set.
// - Interrupt wake runs the handler then continues after sleep.
// - Any reset takes the device out of sleep.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "slc_defs.svh"
module slc_sleep_ctrl (
   input  wire logic              SYS_CLK,
   input  wire logic              RST,
   input  wire logic              CE,
   input  wire logic [3:0]        AVS_ADDRESS,
   input  wire logic              AVS_READ,
   input  wire logic              AVS_WRITE,
   input  wire logic [3:0]        AVS_BYTEENABLE,
   input  wire logic [31:0]       AVS_WRITEDATA,
   output logic      [31:0]       AVS_READDATA,
   output logic                   AVS_WAITREQUEST,
   output logic      [1:0]        AVS_RESPONSE,
   input  wire logic              SLEEP_INSTR,
   input  wire logic              GLOBAL_IRQ_EN,
   input  wire logic [10:0]       IRQ_REQ,
   input  wire logic [10:0]       IRQ_EN,
   input  wire logic              DEBUG_BREAK,
   input  wire logic              BOD_READY,
   input  wire logic [1:0]        BOD_ACTIVE_CFG,
   input  wire logic              OSC_READY,
   output logic                   CPU_HALT,
   output logic                   CPU_RESUME,
   output logic [7:0]             PERIPH_RUN,
   output logic                   MAIN_CLK_RUN,
   output logic                   CCL_CLK_RUN,
   output logic                   RTC_CLK_RUN,
   output slc_pkg::slc_state_e    STATE
);
   import slc_pkg::*;
   slc_byte_t   ctrl;
   slc_byte_t   standby_run;
   slc_byte_t   cfg;
   slc_state_e  state;
   slc_state_e  next_state;
   logic [1:0]  sleep_mode;
   logic [7:0]  cnt;
   logic        osc_stopped;
   logic [10:0] irq_m;
   logic [10:0] irq_s;
   logic [1:0]  dbg_s;
   logic [1:0]  bod_s;
   logic [1:0]  osc_s;
   logic        ack;
   logic [7:0]  g_periph;
   logic        g_main;
   logic        g_ccl;
   logic        g_rtc;
   logic        sel_ctrl;
   logic        sel_stby;
   logic        sel_cfg;
   logic        sel_status;
   logic        sleep_ok;
   logic [1:0]  filter_mode;
   slc_wake_if  wk ();

   // Pin-side inputs through two flip-flops
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         irq_m <= 11'h000;
         irq_s <= 11'h000;
         dbg_s <= 2'b00;
         bod_s <= 2'b00;
         osc_s <= 2'b00;
      end else if (CE) begin
         irq_m <= IRQ_REQ;
         irq_s <= irq_m;
         dbg_s <= {dbg_s[0], DEBUG_BREAK};
         bod_s <= {bod_s[0], BOD_READY};
         osc_s <= {osc_s[0], OSC_READY};
      end
   end

   assign wk.mode = filter_mode;
   assign wk.standby_run = standby_run;
   // Lookup path asynchronous when filter select (cfg[1:0]) and edge detector (cfg[2]) are zero
   assign wk.lut_async = (cfg[2:0] == 3'h0);

   slc_wake_filter u_filter (
      .clk      (SYS_CLK),
      .ce       (CE),
      .rst      (RST),
      .irq_sync (irq_s),
      .irq_en   (IRQ_EN & {11{GLOBAL_IRQ_EN}}),
      .wk       (wk)
   );

   slc_gates u_gates (
      .asleep       (state == SLC_SLEEP || state == SLC_STUCK),
      .mode         (sleep_mode),
      .standby_run  (standby_run),
      .periph_run   (g_periph),
      .main_clk_run (g_main),
      .ccl_clk_run  (g_ccl),
      .rtc_clk_run  (g_rtc)
   );

   // Register select from the byte address
   always_comb begin
      sel_ctrl = 1'b0;
      sel_stby = 1'b0;
      sel_cfg = 1'b0;
      sel_status = 1'b0;
      if (AVS_ADDRESS == `SLC_OFS_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (AVS_ADDRESS == `SLC_OFS_STANDBY_RUN) begin
         sel_stby = 1'b1;
      end else if (AVS_ADDRESS == `SLC_OFS_CFG) begin
         sel_cfg = 1'b1;
      end else if (AVS_ADDRESS == `SLC_OFS_STATUS) begin
         sel_status = 1'b1;
      end
   end

   // Sleep request counts only when armed with a defined mode
   always_comb begin
      sleep_ok = ctrl[`SLC_CTRL_ARM_BIT] && (ctrl[`SLC_CTRL_MODE_MSB:`SLC_CTRL_MODE_LSB] != `SLC_MODE_RESERVED);
   end

   // Wake filter judges by the requested mode on the entry edge, then by the captured one
   always_comb begin
      filter_mode = sleep_mode;
      if (state == SLC_ACTIVE) begin
         filter_mode = ctrl[`SLC_CTRL_MODE_MSB:`SLC_CTRL_MODE_LSB];
      end
   end

   // Register slave: one wait cycle, then acknowledge
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ack <= 1'b0;
      end else if (CE) begin
         ack <= (AVS_READ | AVS_WRITE) & ~ack;
      end
   end

   always_comb begin
      AVS_WAITREQUEST = ~ack;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ctrl <= `SLC_CTRL_RESET;
         standby_run <= `SLC_STBY_RESET;
         cfg <= `SLC_CFG_RESET;
      end else if (CE && AVS_WRITE && ack && AVS_BYTEENABLE[0]) begin
         if (sel_ctrl) begin
            ctrl <= {5'h00, AVS_WRITEDATA[2:0]};
         end else if (sel_stby) begin
            standby_run <= AVS_WRITEDATA[7:0];
         end else if (sel_cfg) begin
            cfg <= AVS_WRITEDATA[7:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         AVS_READDATA <= 32'h0000_0000;
         AVS_RESPONSE <= 2'b00;
      end else if (CE && AVS_READ && !ack) begin
         AVS_RESPONSE <= 2'b00;
         if (sel_ctrl) begin
            AVS_READDATA <= {24'h00_0000, ctrl};
         end else if (sel_stby) begin
            AVS_READDATA <= {24'h00_0000, standby_run};
         end else if (sel_cfg) begin
            AVS_READDATA <= {24'h00_0000, cfg};
         end else if (sel_status) begin
            AVS_READDATA <= {24'h00_0000, osc_stopped, 4'h0, state};
         end else begin
            AVS_READDATA <= 32'h0000_0000;
            AVS_RESPONSE <= 2'b10;
         end
      end
   end

   // Sleep state machine
   always_comb begin
      next_state = state;
      case (state)
         SLC_ACTIVE: begin
            if (SLEEP_INSTR && sleep_ok) begin
               next_state = SLC_SLEEP;
            end
         end
         SLC_SLEEP: begin
            if (dbg_s[1]) begin
               next_state = osc_stopped ? SLC_OSC : SLC_WAKE;
            end else if (!wk.any_enabled) begin
               next_state = SLC_STUCK;
            end else if (wk.wake) begin
               next_state = osc_stopped ? SLC_OSC : SLC_WAKE;
            end
         end
         SLC_STUCK: begin
            if (dbg_s[1]) begin
               next_state = osc_stopped ? SLC_OSC : SLC_WAKE;
            end
         end
         SLC_OSC: begin
            if (cnt == 8'h00 && osc_s[1]) begin
               next_state = SLC_WAKE;
            end
         end
         SLC_WAKE: begin
            if (cnt == 8'h00) begin
               next_state = (BOD_ACTIVE_CFG == `SLC_BOD_WAIT_CODE && !bod_s[1]) ? SLC_BOD : SLC_ACTIVE;
            end
         end
         SLC_BOD: begin
            if (bod_s[1]) begin
               next_state = SLC_ACTIVE;
            end
         end
         default: begin
            next_state = SLC_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state <= SLC_ACTIVE;
      end else if (CE) begin
         state <= next_state;
      end
   end

   // Mode captured at sleep entry
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         sleep_mode <= `SLC_MODE_IDLE;
         osc_stopped <= 1'b0;
      end else if (CE && state == SLC_ACTIVE && next_state == SLC_SLEEP) begin
         sleep_mode <= ctrl[`SLC_CTRL_MODE_MSB:`SLC_CTRL_MODE_LSB];
         osc_stopped <= (ctrl[2:1] == `SLC_MODE_POWER_DOWN) ||
                        (ctrl[2:1] == `SLC_MODE_STANDBY && !standby_run[`SLC_PERIPH_MAIN_CLK]);
      end
   end

   // Wake counters
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cnt <= 8'h00;
      end else if (CE) begin
         if (next_state == SLC_OSC && state != SLC_OSC) begin
            cnt <= `SLC_OSC_START_CLKS - 8'h01;
         end else if (next_state == SLC_WAKE && state != SLC_WAKE) begin
            cnt <= {4'h0, `SLC_WAKE_CLKS} - 8'h01;
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         CPU_HALT <= 1'b0;
         CPU_RESUME <= 1'b0;
         PERIPH_RUN <= 8'hFF;
         MAIN_CLK_RUN <= 1'b1;
         CCL_CLK_RUN <= 1'b1;
         RTC_CLK_RUN <= 1'b1;
         STATE <= SLC_ACTIVE;
      end else if (CE) begin
         CPU_HALT <= (next_state != SLC_ACTIVE);
         CPU_RESUME <= (state != SLC_ACTIVE) && (next_state == SLC_ACTIVE);
         PERIPH_RUN <= g_periph;
         MAIN_CLK_RUN <= g_main;
         CCL_CLK_RUN <= g_ccl;
         RTC_CLK_RUN <= g_rtc;
         STATE <= next_state;
      end
   end
endmodule : slc_sleep_ctrl

// file: verif/slc_osc_model.sv
// Main oscillator model that answers a run request after a start-up lag
`timescale 1ns/1ns
module slc_osc_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [5:0] lag,
   output logic            ready
);
   logic [5:0] count;
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         count <= 6'h0;
         ready <= 1'b0;
      end else if (count < lag) begin
         count <= count + 6'h1;
      end else begin
         ready <= 1'b1;
      end
   end
endmodule : slc_osc_model

// file: verif/slc_sleep_ctrl_checker.sv
// Port-level assertions of the sleep controller
`timescale 1ns/1ns
module slc_sleep_ctrl_checker
   import slc_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic        AVS_WAITREQUEST,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        SLEEP_INSTR,
   input wire logic        DEBUG_BREAK,
   input wire logic        CPU_HALT,
   input wire logic        CPU_RESUME,
   input wire slc_state_e  STATE
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   sequence s_req;
      $rose(AVS_READ || AVS_WRITE);
   endsequence
   sequence s_ack;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   sequence s_wake;
      (STATE == SLC_WAKE) [*6] ##1 (STATE != SLC_WAKE);
   endsequence
   chk_ack_timing: assert property (s_req |-> s_ack) else $error("bus answer out of time");
   chk_reset_state: assert property (disable iff (1'b0) RST |=> STATE == SLC_ACTIVE && !CPU_HALT
      && AVS_READDATA == 32'h0000_0000) else $error("reset left state");
   chk_only_instr: assert property (!SLEEP_INSTR && STATE == SLC_ACTIVE |=> STATE == SLC_ACTIVE)
      else $error("left active without instruction");
   chk_halt_sleep: assert property (STATE == SLC_SLEEP || STATE == SLC_STUCK |-> CPU_HALT)
      else $error("cpu runs while asleep");
   chk_wake_six: assert property ($rose(STATE == SLC_WAKE) |-> s_wake) else $error("wake length wrong");
   chk_resume_once: assert property (CPU_RESUME |=> !CPU_RESUME) else $error("resume too long");
   chk_stuck_hold: assert property (STATE == SLC_STUCK && !$past(DEBUG_BREAK, 2) |=> STATE == SLC_STUCK)
      else $error("left stuck sleep");
   chk_debug_wake: assert property ($rose(DEBUG_BREAK) |-> ##[1:150] STATE == SLC_ACTIVE)
      else $error("break did not wake");
endmodule : slc_sleep_ctrl_checker
bind slc_sleep_ctrl slc_sleep_ctrl_checker chk (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
   .SLEEP_INSTR(SLEEP_INSTR), .DEBUG_BREAK(DEBUG_BREAK), .CPU_HALT(CPU_HALT), .CPU_RESUME(CPU_RESUME),
   .STATE(STATE));

// file: verif/slc_sleep_ctrl_test.sv
// Self-checking bench of the sleep controller
`timescale 1ns/1ns
`include "slc_defs.svh"
module slc_sleep_ctrl_test;
   import slc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] wdat = 32'h0000_0000;
   logic        sl = 1'b0;
   logic [10:0] req = 11'h000;
   logic [10:0] en = 11'h7ff;
   logic        dbg = 1'b0;
   logic        gie = 1'b1;
   logic        ce = 1'b1;
   logic        bod_rdy = 1'b1;
   logic [1:0]  bod_cfg = 2'h0;
   logic        osc_rdy, halt, resume, mclk, cclk, rclk, wait_n;
   logic [31:0] rdat;
   logic [1:0]  resp;
   logic [7:0]  prun;
   slc_state_e  st;
   int          n_mismatch = 0;
   int          tests_run = 0;
   logic [31:0] seed = 32'h0000_034b;
   always #20 clk = ~clk;
   slc_sleep_ctrl dut (.SYS_CLK(clk), .RST(rst), .CE(ce), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_n),
      .AVS_RESPONSE(resp), .SLEEP_INSTR(sl), .GLOBAL_IRQ_EN(gie), .IRQ_REQ(req), .IRQ_EN(en),
      .DEBUG_BREAK(dbg), .BOD_READY(bod_rdy), .BOD_ACTIVE_CFG(bod_cfg), .OSC_READY(osc_rdy),
      .CPU_HALT(halt), .CPU_RESUME(resume), .PERIPH_RUN(prun), .MAIN_CLK_RUN(mclk),
      .CCL_CLK_RUN(cclk), .RTC_CLK_RUN(rclk), .STATE(st));
   slc_osc_model osc (.clk(clk), .rst(rst), .run(mclk), .lag(6'h04), .ready(osc_rdy));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic may_wake(input int m, input int s, input logic [7:0] sr, input logic asy);
      if (m == 0) return 1'b1;
      if (m == 1) begin
         case (s)
            0, 1, 2, 6: return 1'b1;
            3: return sr[1] & asy;
            4, 5: return sr[0];
            8: return sr[2];
            default: return 1'b0;
         endcase
      end
      case (s)
         0, 1, 2, 4: return 1'b1;
         3: return asy;
         default: return 1'b0;
      endcase
   endfunction : may_wake
   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      be <= b;
      do begin
         @(posedge clk);
         n++;
      end while (wait_n !== 1'b0 && n < 50);
      q = rdat;
      r = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) cmp(1, 0, "no bus answer");
   endtask : bus
   task automatic go_sleep(input logic [7:0] c);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b1, 4'h0, {24'h00_0000, c}, 4'hf, q, r);
      @(posedge clk);
      sl <= 1'b1;
      @(posedge clk);
      sl <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : go_sleep
   task automatic wake_by_break();
      logic slept;
      slept = (st !== SLC_ACTIVE);
      dbg <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 150 && st !== SLC_ACTIVE; i++) @(posedge clk);
      dbg <= 1'b0;
      cmp(st, SLC_ACTIVE, "break wake");
      cmp(resume, slept, "resume pulse");
   endtask : wake_by_break
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      logic [31:0] q;
      logic [31:0] w;
      logic [1:0]  r;
      logic [7:0]  sr;
      logic [2:0]  cf;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, q, r);
      cmp(q, `SLC_CTRL_RESET, "ctrl reset");
      w = rnd();
      bus(1'b1, 4'h0, w | 32'h0000_00f8, 4'hf, q, r);
      bus(1'b1, 4'h0, 32'h0000_0000, 4'h0, q, r);
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, q, r);
      cmp(q, (w & 32'h0000_0007) | 32'h0000_0000, "ctrl bits");
      cmp(st, SLC_ACTIVE, "write only");
      bus(1'b0, 4'h2, 32'h0000_0000, 4'hf, q, r);
      cmp(q, 32'h0000_0000, "unmapped data");
      cmp(r, 2'b10, "unmapped response");
      $display("test registers done");
      go_sleep(8'h02);
      cmp(st, SLC_ACTIVE, "unarmed");
      go_sleep(8'h07);
      cmp({halt, st}, {1'b0, SLC_ACTIVE}, "reserved mode");
      $display("test arming done");
      for (int m = 0; m < 3; m++) begin
         for (int s = 0; s < 11; s++) begin
            q = rnd();
            sr = q[7:0] | 8'h08;
            cf = q[10:8] & {3{q[11]}};
            bus(1'b1, 4'h4, {24'h00_0000, sr}, 4'hf, q, r);
            bus(1'b1, 4'h8, {29'h0000_0000, cf}, 4'hf, q, r);
            go_sleep({5'h00, m[1:0], 1'b1});
            cmp({halt, st}, {1'b1, SLC_SLEEP}, "asleep");
            cmp(prun, (m == 0) ? 8'hff : (m == 1) ? sr : 8'h01, "run");
            cmp(mclk, m == 0 || (m == 1 && sr[4]), "main clk");
            cmp(cclk, m == 0 || (m == 1 && sr[1]), "logic clk");
            cmp(rclk, m == 2 || m == 0 || sr[0], "rtc clk");
            req <= 11'h001 << s;
            repeat (80) @(posedge clk);
            cmp(st, may_wake(m, s, sr, cf == 3'h0) ? SLC_ACTIVE : SLC_SLEEP, "wake");
            req <= 11'h000;
            wake_by_break();
         end
      end
      $display("test wake sources done");
      for (int k = 0; k < 2; k++) begin
         en <= (k == 0) ? 11'h000 : 11'h7ff;
         gie <= (k == 0) ? 1'b1 : 1'b0;
         go_sleep(8'h01);
         req <= 11'h7ff;
         repeat (30) @(posedge clk);
         cmp(st, SLC_STUCK, "no wake source");
         req <= 11'h000;
         en <= 11'h7ff;
         gie <= 1'b1;
         wake_by_break();
      end
      $display("test stuck done");
      bod_cfg <= `SLC_BOD_WAIT_CODE;
      bod_rdy <= 1'b0;
      go_sleep(8'h01);
      req <= 11'h001;
      repeat (40) @(posedge clk);
      cmp(st, SLC_BOD, "wait brownout");
      bod_rdy <= 1'b1;
      repeat (10) @(posedge clk);
      cmp(st, SLC_ACTIVE, "brownout ready");
      req <= 11'h000;
      bod_cfg <= 2'h0;
      $display("test brownout done");
      go_sleep(8'h03);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cmp({halt, st}, {1'b0, SLC_ACTIVE}, "reset wake");
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, q, r);
      cmp(q, `SLC_CTRL_RESET, "ctrl after reset");
      $display("test reset done");
      bus(1'b1, 4'h0, 32'h0000_0001, 4'hf, q, r);
      ce <= 1'b0;
      @(posedge clk);
      sl <= 1'b1;
      @(posedge clk);
      sl <= 1'b0;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      cmp({halt, st}, {1'b0, SLC_ACTIVE}, "frozen by enable");
      $display("test clock enable done");
      conclude();
   end
endmodule : slc_sleep_ctrl_test
